//--- rtl/chie_pkg.sv
/*
 * Shared constants and types for the per-channel interrupt enable block.
 * Assumes a byte-wide register port whose address and strobes come from
 * the device's own microprocessor interface decoder.
 */
package chie_pkg;

	localparam int CHIE_NCH = 3;
	localparam int CHIE_NSRC = 4;
	localparam int CHIE_AW = 8;
	localparam int CHIE_DW = 8;

	// Register offsets, one entry per channel.
	localparam logic [CHIE_AW-1:0] CHIE_EN_OFF [CHIE_NCH] = '{8'h01, 8'h09, 8'h11};
	localparam logic [CHIE_AW-1:0] CHIE_STAT_OFF [CHIE_NCH] = '{8'h02, 8'h0A, 8'h12};
	localparam logic [CHIE_AW-1:0] CHIE_ALARM_OFF [CHIE_NCH] = '{8'h03, 8'h0B, 8'h13};

	// Bit positions inside the enable, status and alarm registers.
	localparam int CHIE_BIT_DRV_MON = 0;
	localparam int CHIE_BIT_SIG_LOSS = 1;
	localparam int CHIE_BIT_LOCK_LOSS = 2;
	localparam int CHIE_BIT_FIFO_LIM = 3;

	// Reset values, and the read value of the unused upper register bits.
	localparam logic [CHIE_NSRC-1:0] CHIE_EN_RST = 4'h0;
	localparam logic [CHIE_NSRC-1:0] CHIE_STAT_RST = 4'h0;
	localparam logic [CHIE_DW-1:0] CHIE_RD_IDLE = 8'h00;
	localparam logic [CHIE_DW-CHIE_NSRC-1:0] CHIE_UNUSED_BITS = 4'h0;

	// Source conditions of one channel; packed order matches register bits 3..0.
	typedef struct packed {
		logic fifo_limit_alarm;
		logic loss_of_lock;
		logic loss_of_signal;
		logic drive_monitor_output;
	} chie_cond_t;

	// One register port request.
	typedef struct packed {
		logic [CHIE_AW-1:0] addr;
		logic wr;
		logic rd;
		logic [CHIE_DW-1:0] wdata;
	} chie_req_t;

endpackage

//--- rtl/chie_channel.sv
/*
 * One channel's enable register, latched change-of-condition status and
 * interrupt request.
 * Assumes single-cycle event pulses and decoded write and read strobes
 * from the parent, all on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module chie_channel (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register access.
	input wire logic en_wr,
	input wire logic [chie_pkg::CHIE_NSRC-1:0] en_wdata,
	input wire logic stat_rd,
	// Change-of-condition pulses.
	input wire logic [chie_pkg::CHIE_NSRC-1:0] change,
	// Register contents and request.
	output logic [chie_pkg::CHIE_NSRC-1:0] enable_q,
	output logic [chie_pkg::CHIE_NSRC-1:0] status_q,
	output logic irq_q
);
	import chie_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_q <= CHIE_EN_RST;
		end else if (en_wr) begin
			enable_q <= en_wdata; // [RQ6]
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// A change in the same cycle as the clearing read survives the clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= CHIE_STAT_RST;
		end else if (stat_rd) begin
			status_q <= change; // [RQ8]
		end else begin
			status_q <= status_q | change; // [RQ8]
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & enable_q); // [RQ2] [RQ3] [RQ4] [RQ5] [RQ10]
		end
	end

endmodule
`default_nettype wire

//--- rtl/chie_top.sv
/*
 * Per-channel source-level interrupt enable and status for three line
 * interface channels, with the current alarm levels readable beside them.
 * Assumes the source conditions arrive from detectors on other clocks, and
 * that the register port strobes are single-cycle pulses on clk.
 */
// Function
// (RQ1) Enable registers at 0x01, 0x09, 0x11.
// (RQ2) Bit 3: fifo limit alarm change interrupts.
// (RQ3) Bit 2: loss of lock change interrupts.
// (RQ4) Bit 1: loss of signal change interrupts.
// (RQ5) Bit 0: drive monitor output toggles interrupt.
// (RQ6) Enable bits read/write; one enables, zero disables.
// (RQ7) Status registers at 0x02, 0x0A, 0x12.
// (RQ8) Status bits latch changes, clear on read.
// (RQ9) Current condition levels readable in alarm register.
// (RQ10) Request while enabled status bit is set.
`timescale 1ns/1ps
`default_nettype none

module chie_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port.
	input wire chie_pkg::chie_req_t req,
	output logic [chie_pkg::CHIE_DW-1:0] rdata_q,
	// Source conditions from the channel detectors.
	input wire chie_pkg::chie_cond_t [chie_pkg::CHIE_NCH-1:0] cond,
	// Interrupt requests, one per channel.
	output logic [chie_pkg::CHIE_NCH-1:0] irq
);
	import chie_pkg::*;

	localparam int NBITS = CHIE_NCH * CHIE_NSRC;

	logic [NBITS-1:0] raw;
	logic [NBITS-1:0] sync1_q;
	logic [NBITS-1:0] sync2_q;
	logic [NBITS-1:0] sync3_q;
	logic [NBITS-1:0] level_q;
	logic [NBITS-1:0] change;
	logic [NBITS-1:0] agree;
	logic [CHIE_NCH-1:0] en_wr;
	logic [CHIE_NCH-1:0] stat_rd;
	logic [CHIE_NCH-1:0] en_hit;
	logic [CHIE_NCH-1:0] stat_hit;
	logic [CHIE_NCH-1:0] alarm_hit;
	logic [CHIE_NSRC-1:0] enable_q [CHIE_NCH];
	logic [CHIE_NSRC-1:0] status_q [CHIE_NCH];
	logic [CHIE_DW-1:0] rdata_d;

	////////////////////////////////////////////////////////////////////////////
	// Source mapping. Every condition is placed on its register bit by name,
	// so a change to the struct order cannot swap two sources unnoticed.

	for (genvar c = 0; c < CHIE_NCH; c++) begin : g_map
		assign raw[c*CHIE_NSRC + CHIE_BIT_FIFO_LIM] = cond[c].fifo_limit_alarm; // [RQ2]
		assign raw[c*CHIE_NSRC + CHIE_BIT_LOCK_LOSS] = cond[c].loss_of_lock; // [RQ3]
		assign raw[c*CHIE_NSRC + CHIE_BIT_SIG_LOSS] = cond[c].loss_of_signal; // [RQ4]
		assign raw[c*CHIE_NSRC + CHIE_BIT_DRV_MON] = cond[c].drive_monitor_output; // [RQ5]
	end

	////////////////////////////////////////////////////////////////////////////
	// Condition synchronisers and change detection.
	// A level is accepted only once the second and third stages agree, so a
	// glitch shorter than a clock never reaches the status bits.

	for (genvar b = 0; b < NBITS; b++) begin : g_sync
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				sync1_q[b] <= 1'b0;
				sync2_q[b] <= 1'b0;
				sync3_q[b] <= 1'b0;
			end else begin
				sync1_q[b] <= raw[b];
				sync2_q[b] <= sync1_q[b];
				sync3_q[b] <= sync2_q[b];
			end
		end

		// Both declaring and clearing a condition count as a change.
		assign agree[b] = (sync2_q[b] == sync3_q[b]);
		assign change[b] = agree[b] && (sync3_q[b] != level_q[b]);

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				level_q[b] <= 1'b0;
			end else if (change[b]) begin
				level_q[b] <= sync3_q[b]; // [RQ9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode and the channel slices.

	for (genvar c = 0; c < CHIE_NCH; c++) begin : g_chan
		assign en_hit[c] = (req.addr == CHIE_EN_OFF[c]); // [RQ1]
		assign stat_hit[c] = (req.addr == CHIE_STAT_OFF[c]); // [RQ7]
		assign alarm_hit[c] = (req.addr == CHIE_ALARM_OFF[c]); // [RQ9]
		assign en_wr[c] = req.wr && en_hit[c]; // [RQ6]
		assign stat_rd[c] = req.rd && stat_hit[c]; // [RQ8]

		chie_channel u_chan (
			.clk(clk),
			.rst_b(rst_b),
			.en_wr(en_wr[c]),
			.en_wdata(req.wdata[CHIE_NSRC-1:0]),
			.stat_rd(stat_rd[c]),
			.change(change[c*CHIE_NSRC +: CHIE_NSRC]), // [RQ2] [RQ3] [RQ4] [RQ5]
			.enable_q(enable_q[c]),
			.status_q(status_q[c]),
			.irq_q(irq[c])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data. Addresses outside this block read as zero; the unused upper
	// bits of every register read as zero too.

	always_comb begin
		rdata_d = CHIE_RD_IDLE;
		for (int c = 0; c < CHIE_NCH; c++) begin
			if (en_hit[c]) begin
				rdata_d = {CHIE_UNUSED_BITS, enable_q[c]}; // [RQ1] [RQ6]
			end
			if (stat_hit[c]) begin
				rdata_d = {CHIE_UNUSED_BITS, status_q[c]}; // [RQ7] [RQ8]
			end
			if (alarm_hit[c]) begin
				rdata_d = {CHIE_UNUSED_BITS, level_q[c*CHIE_NSRC +: CHIE_NSRC]}; // [RQ9]
			end
		end
	end

	// The status value is captured at the same edge that clears it, so a read
	// returns exactly the changes it acknowledges.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= CHIE_RD_IDLE;
		end else if (req.rd) begin
			rdata_q <= rdata_d;
		end
	end

endmodule
`default_nettype wire

//--- sim/chie_assertions.sv
/* Port checker for chie_top.
 Assumes bench inputs change on the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module chie_assertions (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports.
	input wire chie_pkg::chie_req_t req,
	input wire logic [7:0] rdata_q,
	input wire chie_pkg::chie_cond_t [2:0] cond,
	input wire logic [2:0] irq
);
import chie_pkg::*;
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
////////////////
a_upper_zero: assert property (rdata_q[7:4] == 4'h0)
	else $error("upper bits set");
a_unmapped_zero: assert property (req.rd && req.addr > 8'h13 |=> rdata_q == 8'h00)
	else $error("unmapped read");
a_en_readback: assert property (req.wr && req.addr == 8'h01 ##1 req.rd && req.addr == 8'h01
	|=> rdata_q == ($past(req.wdata, 2) & 8'h0F)) else $error("enable readback");
// Stable input for six samples leaves no change queued in the synchroniser.
a_stat_clears: assert property ($stable(cond[0]) [*6] ##0 req.rd && req.addr == 8'h02
	##1 req.rd && req.addr == 8'h02 |=> rdata_q == 8'h00) else $error("status kept");
a_irq_off_drop: assert property (req.wr && req.addr == 8'h01 && req.wdata[3:0] == 4'h0
	|=> ##1 !irq[0]) else $error("irq after disable");
a_irq_stays_off: assert property (req.wr && req.addr == 8'h11 && req.wdata[3:0] == 4'h0
	##1 !req.wr [*3] |=> !irq[2]) else $error("irq while disabled");
a_alarm_level: assert property ($stable(cond[1]) [*5] ##0 req.rd && req.addr == 8'h0B
	|=> rdata_q == {4'h0, $past(cond[1])}) else $error("alarm level");
a_irq_cause: assert property ($rose(irq[0]) |-> $past(req.wr, 2)
	|| $past(cond[0], 5) != $past(cond[0], 6)) else $error("irq without cause");
endmodule
bind chie_top chie_assertions u_chie_assertions (.clk(clk), .rst_b(rst_b), .req(req),
	.rdata_q(rdata_q), .cond(cond), .irq(irq));
`default_nettype wire

//--- sim/tb.sv
/* Self-checking bench for chie_top.
 Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module tb;
import chie_pkg::*;
logic clk = 1'b0;
logic rst_b = 1'b0;
chie_req_t req = '0;
chie_cond_t [2:0] cond = '0;
logic [7:0] rdata_q;
logic [2:0] irq;
int fail_count = 0;
int num_checks = 0;
int cyc = 0;
always #20 clk = ~clk;
chie_top u_chie_top (.clk(clk), .rst_b(rst_b), .req(req), .rdata_q(rdata_q), .cond(cond), .irq(irq));
////////////////
task automatic end_sim();
	if (fail_count == 0 && num_checks > 0) begin
		$display("ALL CHECKS OK");
	end else begin
		$display("CHECKS NOT OK");
	end
	$finish;
endtask
task automatic chk(logic [7:0] seen, logic [7:0] exp, string nm);
	num_checks++;
	if (seen !== exp) begin
		fail_count++;
		$display("BAD %s exp %h seen %h", nm, exp, seen);
	end
endtask
task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
	@(negedge clk);
	req = '{a, w, r, d};
endtask
task automatic rd(logic [7:0] a, logic [7:0] exp);
	op(1'b0, 1'b1, a, 8'h00);
	op(1'b0, 1'b0, a, 8'h00);
	chk(rdata_q, exp, "rdata");
endtask
// Six idle cycles cover the synchroniser, the status latch and the irq register.
task automatic chan(int c);
	logic [7:0] eo;
	eo = 8'h01 + 8'(8 * c);
	rd(eo, 8'h00);
	op(1'b1, 1'b0, eo, 8'hFF);
	rd(eo, 8'h0F);
	for (int b = 0; b < 4; b++) begin
		cond[c][b] = 1'b1;
		repeat (6) op(1'b0, 1'b0, 8'h00, 8'h00);
		chk({7'h00, irq[c]}, 8'h01, "irq");
		rd(eo + 8'h01, 8'h01 << b);
		rd(eo + 8'h02, 8'h01 << b);
		chk({7'h00, irq[c]}, 8'h00, "irq");
		cond[c][b] = 1'b0;
		repeat (6) op(1'b0, 1'b0, 8'h00, 8'h00);
		rd(eo + 8'h01, 8'h01 << b);
	end
	op(1'b1, 1'b0, eo, 8'hF0);
	rd(eo, 8'h00);
	cond[c][0] = 1'b1;
	repeat (6) op(1'b0, 1'b0, 8'h00, 8'h00);
	chk({7'h00, irq[c]}, 8'h00, "irq");
	rd(eo + 8'h01, 8'h01);
	cond[c][0] = 1'b0;
endtask
task automatic idle(int n);
	repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
endtask
// Reset values, ignored writes, unmapped reads and back-to-back status reads.
task automatic map_basics();
	rd(8'h02, 8'h00);
	op(1'b1, 1'b0, 8'h03, 8'hFF);
	rd(8'h03, 8'h00);
	rd(8'h20, 8'h00);
	op(1'b0, 1'b1, 8'h02, 8'h00);
	rd(8'h02, 8'h00);
endtask
// One enable bit gates only its own source; a change in the read cycle survives the clear.
task automatic gate_one();
	rd(8'h0A, 8'h01);
	op(1'b1, 1'b0, 8'h09, 8'h04);
	cond[1][1] = 1'b1;
	idle(6);
	chk({7'h00, irq[1]}, 8'h00, "irq_gate");
	rd(8'h0A, 8'h02);
	cond[1][2] = 1'b1;
	idle(6);
	chk({7'h00, irq[1]}, 8'h01, "irq_gate");
	rd(8'h0A, 8'h04);
	idle(1);
	chk({7'h00, irq[1]}, 8'h00, "irq_gate");
	cond[1][1] = 1'b0;
	cond[1][2] = 1'b0;
	idle(6);
	rd(8'h0A, 8'h06);
	cond[1][3] = 1'b1;
	idle(2);
	rd(8'h0A, 8'h00);
	rd(8'h0A, 8'h08);
	op(1'b1, 1'b0, 8'h09, 8'h00);
	cond[1][3] = 1'b0;
endtask
// A condition held across a mid-run reset shows up again as a change after release.
task automatic mid_reset();
	op(1'b1, 1'b0, 8'h11, 8'h02);
	cond[2][1] = 1'b1;
	idle(6);
	chk({7'h00, irq[2]}, 8'h01, "irq_pre");
	rst_b = 1'b0;
	@(negedge clk);
	chk({5'h00, irq}, 8'h00, "irq_rst");
	@(negedge clk);
	rst_b = 1'b1;
	rd(8'h11, 8'h00);
	idle(2);
	rd(8'h12, 8'h02);
	chk({7'h00, irq[2]}, 8'h00, "irq_post");
	cond[2][1] = 1'b0;
endtask
initial begin
	repeat (4) @(posedge clk);
	@(negedge clk);
	rst_b = 1'b1;
	map_basics();
	for (int c = 0; c < 3; c++) begin
		chan(c);
	end
	gate_one();
	mid_reset();
	end_sim();
end
always @(posedge clk) begin
	cyc++;
	if (cyc == 4000) begin
		fail_count++;
		end_sim();
	end
end
endmodule
`default_nettype wire
